/* File: core/clu_top.sv */
// Custom logic unit: four lookup tables, two sequencers, APB registers
`timescale 1ns/1ps

// What this block does
// - Output is truth bit indexed by inputs
// - Sequencer 0 serves tables 0,1; 1 serves 2,3
// - Select codes 0 to 6 pick base sources
// - Codes 8, 9, C pick serial, spi, timer B
// - Code A picks timer A; others reserved
// - Inputs 0,1 in control B, 2 in C
// - Feedback code feeds the pair sequencer output
// - Link code feeds next table, 3 wraps
// - Pin code feeds the table's own pin
// - Protected fields written only while even disabled
// - Protected fields also accepted with the enabling write
// - Global enable bit switches the whole unit
// - Control A enable bit switches each table
// - Switched off input reads as low
// - Sync option delays output two table edges
// - Filter passes stable values, four edge lag
// - Filter state clears one cycle after disable
// - Edge detector pulses on rising filtered output
// - Edge state clears one cycle after disable
// - Output pin per table; input 2 clocks
// - Output changes can raise an interrupt
// - Interrupt on rising, falling or both edges
// - Sequencer functions DFF, JK, D latch, RS
// - Clock select uses input 2, masks it
module clu_top
   import clu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Signal sources
   input wire clu_src_t src_i,
   // Outputs
   output logic [CLU_TABLES-1:0] table_output_pin_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   clu_ctrl_a_t ctrl_a_reg [CLU_TABLES];
   logic [3:0] sel0_reg [CLU_TABLES];
   logic [3:0] sel1_reg [CLU_TABLES];
   logic [3:0] sel2_reg [CLU_TABLES];
   logic [7:0] truth_reg [CLU_TABLES];
   logic [3:0] seq_fn_reg [CLU_PAIRS];
   logic glob_en_reg;
   logic [7:0] int_mode_reg;
   logic [CLU_TABLES-1:0] int_flag_reg;
   logic [CLU_TABLES-1:0] out_prev_reg;
   logic [CLU_TABLES-1:0] link_reg;
   logic [CLU_TABLES-1:0] in2_prev_reg;
   logic [CLU_ASYNC_W-1:0] sync1_reg;
   logic [CLU_ASYNC_W-1:0] sync2_reg;

   logic [CLU_ASYNC_W-1:0] async_raw;
   logic [11:0] pins_s;
   logic [3:0] evt_a_s;
   logic [3:0] evt_b_s;
   logic cmp_s;
   logic [CLU_TABLES-1:0] tbl_en;
   logic [CLU_TABLES-1:0] tick;
   logic [CLU_TABLES-1:0] lut_out;
   logic [CLU_TABLES-1:0] fin_out;
   logic [CLU_TABLES-1:0] int_set;
   logic [CLU_PAIRS-1:0] seq_out;
   logic access, wr, glob_hit, tbl_hit, hit;
   logic [3:0] gword;
   logic [1:0] tsel;
   logic [1:0] tword;

   ////////////////////////////////////////////////////////////////////////////
   // Input selection

   // One table input from its select code
   function automatic logic pick_src(
      input logic [3:0] code,
      input logic [1:0] pos,
      input logic seq_v,
      input logic link_v,
      input logic ev_a,
      input logic ev_b,
      input logic pin_v,
      input logic cmp_v,
      input clu_src_t s
   );
      logic v;
      v = 1'b0;
      case (code)
         CLU_SRC_MASK: v = 1'b0;
         CLU_SRC_FEEDBACK: v = seq_v;
         CLU_SRC_LINK: v = link_v;
         CLU_SRC_EVENT_A: v = ev_a;
         CLU_SRC_EVENT_B: v = ev_b;
         CLU_SRC_PIN: v = pin_v;
         CLU_SRC_COMPARATOR: v = cmp_v;
         CLU_SRC_SERIAL: v = s.serial_tx[pos];
         CLU_SRC_SPI: v = (pos == 2'd2) ? s.spi_sck : s.spi_mosi;
         CLU_SRC_TIMER_A: v = s.timer_a_outputs[pos];
         CLU_SRC_TIMER_B: v = s.timer_b_outputs[pos];
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Synchronizers for pins, events and comparator

   // Events are asynchronous here, so they share the two-flop chain
   assign async_raw = {src_i.table_input_pins, src_i.event_input_b,
                       src_i.event_input_a, src_i.comparator_output_source};

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= async_raw;
         sync2_reg <= sync1_reg;
      end
   end

   assign pins_s = sync2_reg[20:9];
   assign evt_b_s = sync2_reg[8:5];
   assign evt_a_s = sync2_reg[4:1];
   assign cmp_s = sync2_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   // Zero wait states; strobe-free word access only
   assign access = psel_i & penable_i;
   assign gword = paddr_i[5:2];
   assign tsel = paddr_i[5:4];
   assign tword = paddr_i[3:2];
   assign glob_hit = (paddr_i[11:6] == CLU_PAGE_GLOBAL) && (gword <= CLU_W_STATUS);
   assign tbl_hit = (paddr_i[11:6] == CLU_PAGE_TABLE);
   assign hit = (glob_hit | tbl_hit) && (paddr_i[1:0] == 2'b00);
   assign wr = access & pwrite_i & hit;
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~hit;

   // Read mux
   always_comb begin
      prdata_o = 32'h0000_0000;
      if (psel_i && !pwrite_i && hit) begin
         if (glob_hit) begin
            unique case (gword)
               CLU_W_GLOBAL: prdata_o = {31'h0000_0000, glob_en_reg};
               CLU_W_PAIR_SEQUENCER_0: prdata_o = {28'h000_0000, seq_fn_reg[0]};
               CLU_W_PAIR_SEQUENCER_1: prdata_o = {28'h000_0000, seq_fn_reg[1]};
               CLU_W_INT_MODE: prdata_o = {24'h00_0000, int_mode_reg};
               CLU_W_INT_FLAG: prdata_o = {28'h000_0000, int_flag_reg};
               CLU_W_STATUS: prdata_o = {26'h000_0000, seq_out, fin_out};
               default: prdata_o = 32'h0000_0000;
            endcase
         end else begin
            unique case (tword)
               CLU_T_CTRL_A: prdata_o = {27'h000_0000, ctrl_a_reg[tsel]};
               CLU_T_CTRL_B: prdata_o = {24'h00_0000, sel1_reg[tsel], sel0_reg[tsel]};
               CLU_T_CTRL_C: prdata_o = {28'h000_0000, sel2_reg[tsel]};
               CLU_T_TRUTH: prdata_o = {24'h00_0000, truth_reg[tsel]};
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Global registers

   // Whole-unit enable and interrupt mode
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         glob_en_reg <= 1'b0;
         int_mode_reg <= CLU_RST_INT_MODE;
      end else if (wr && glob_hit) begin
         if (gword == CLU_W_GLOBAL) begin
            glob_en_reg <= pwdata_i[0];
         end
         if (gword == CLU_W_INT_MODE) begin
            int_mode_reg <= pwdata_i[7:0];
         end
      end
   end

   // Sequencer function, locked while the even table's enable bit is set
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         seq_fn_reg[0] <= CLU_SEQ_OFF;
         seq_fn_reg[1] <= CLU_SEQ_OFF;
      end else if (wr && glob_hit) begin
         if (gword == CLU_W_PAIR_SEQUENCER_0 && !ctrl_a_reg[0].en) begin
            seq_fn_reg[0] <= pwdata_i[3:0];
         end
         if (gword == CLU_W_PAIR_SEQUENCER_1 && !ctrl_a_reg[2].en) begin
            seq_fn_reg[1] <= pwdata_i[3:0];
         end
      end
   end

   // Sticky flags, write one to clear; new events win
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         int_flag_reg <= '0;
      end else if (wr && glob_hit && gword == CLU_W_INT_FLAG) begin
         int_flag_reg <= int_set | (int_flag_reg & ~pwdata_i[CLU_TABLES-1:0]);
      end else begin
         int_flag_reg <= int_flag_reg | int_set;
      end
   end

   assign irq_o = |int_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencers, one per table pair

   for (genvar p = 0; p < CLU_PAIRS; p++) begin : g_pair
      // Runs on the even table's clock, held clear while it is off
      clu_sequencer u_seq (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .clr_i(~tbl_en[2*p]),
         .tick_i(tick[2*p]),
         .fn_i(seq_fn_reg[p]),
         .a_i(fin_out[2*p]),
         .b_i(fin_out[2*p+1]),
         .q_o(seq_out[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lookup tables

   for (genvar g = 0; g < CLU_TABLES; g++) begin : g_tbl
      localparam int EVEN = (g / 2) * 2;
      localparam int NEXT = (g + 1) % CLU_TABLES;
      logic in0, in1, in2_raw, in2;
      logic protect_ok;
      logic [2:0] idx;

      // Protection follows the even enable before the write
      assign protect_ok = ~ctrl_a_reg[EVEN].en;

      // Table configuration registers
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            ctrl_a_reg[g] <= CLU_RST_CTRL_A;
            sel0_reg[g] <= CLU_RST_SEL;
            sel1_reg[g] <= CLU_RST_SEL;
            sel2_reg[g] <= CLU_RST_SEL;
            truth_reg[g] <= CLU_RST_TRUTH;
         end else if (wr && tbl_hit && tsel == 2'(g)) begin
            unique case (tword)
               CLU_T_CTRL_A: begin
                  ctrl_a_reg[g].en <= pwdata_i[0];
                  if (protect_ok) begin
                     ctrl_a_reg[g].filt <= pwdata_i[2:1];
                     ctrl_a_reg[g].edge_en <= pwdata_i[3];
                     ctrl_a_reg[g].clk_sel <= pwdata_i[4];
                  end
               end
               CLU_T_CTRL_B: begin
                  if (protect_ok) begin
                     sel0_reg[g] <= pwdata_i[3:0];
                     sel1_reg[g] <= pwdata_i[7:4];
                  end
               end
               CLU_T_CTRL_C: begin
                  if (protect_ok) begin
                     sel2_reg[g] <= pwdata_i[3:0];
                  end
               end
               CLU_T_TRUTH: truth_reg[g] <= pwdata_i[7:0];
            endcase
         end
      end

      // Table runs only with both unit and own enable set
      assign tbl_en[g] = glob_en_reg & ctrl_a_reg[g].en;

      // Input muxes; link goes through a flop to break the ring
      assign in0 = pick_src(sel0_reg[g], 2'd0, seq_out[g/2], link_reg[NEXT],
                            evt_a_s[g], evt_b_s[g], pins_s[3*g], cmp_s, src_i);
      assign in1 = pick_src(sel1_reg[g], 2'd1, seq_out[g/2], link_reg[NEXT],
                            evt_a_s[g], evt_b_s[g], pins_s[3*g+1], cmp_s, src_i);
      assign in2_raw = pick_src(sel2_reg[g], 2'd2, seq_out[g/2], link_reg[NEXT],
                                evt_a_s[g], evt_b_s[g], pins_s[3*g+2], cmp_s, src_i);

      // Input 2 masked when it serves as the table clock
      assign in2 = ctrl_a_reg[g].clk_sel ? 1'b0 : in2_raw;
      assign idx = {in2, in1, in0};
      assign lut_out[g] = tbl_en[g] & truth_reg[g][idx];

      // Alternative clock: rising-edge tick of input 2
      assign tick[g] = ctrl_a_reg[g].clk_sel ? (in2_raw & ~in2_prev_reg[g]) : 1'b1;

      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            in2_prev_reg[g] <= 1'b0;
            link_reg[g] <= 1'b0;
            out_prev_reg[g] <= 1'b0;
         end else begin
            in2_prev_reg[g] <= in2_raw;
            link_reg[g] <= lut_out[g];
            out_prev_reg[g] <= fin_out[g];
         end
      end

      // Synchronizer, filter and edge detector
      clu_out_stage u_stage (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .en_i(tbl_en[g]),
         .tick_i(tick[g]),
         .filt_i(ctrl_a_reg[g].filt),
         .edge_en_i(ctrl_a_reg[g].edge_en),
         .d_i(lut_out[g]),
         .q_o(fin_out[g])
      );

      // Change event per edge mode: bit 0 rising, bit 1 falling
      assign int_set[g] = (int_mode_reg[2*g] & fin_out[g] & ~out_prev_reg[g])
                        | (int_mode_reg[2*g+1] & ~fin_out[g] & out_prev_reg[g]);
      assign table_output_pin_o[g] = fin_out[g];
   end

endmodule

/* File: core/clu_pkg.sv */
// Shared constants, field layouts and carrier types of the custom logic unit
package clu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int CLU_TABLES = 4;
   localparam int CLU_PAIRS = 2;
   localparam int CLU_ASYNC_W = 21;

   ////////////////////////////////////////////////////////////////////////////
   // Register word indices, global block
   localparam logic [3:0] CLU_W_GLOBAL = 4'h0;
   localparam logic [3:0] CLU_W_PAIR_SEQUENCER_0 = 4'h1;
   localparam logic [3:0] CLU_W_PAIR_SEQUENCER_1 = 4'h2;
   localparam logic [3:0] CLU_W_INT_MODE = 4'h3;
   localparam logic [3:0] CLU_W_INT_FLAG = 4'h4;
   localparam logic [3:0] CLU_W_STATUS = 4'h5;
   // Table block: 0x40 + 0x10 * table, word select below
   localparam logic [5:0] CLU_PAGE_GLOBAL = 6'h00;
   localparam logic [5:0] CLU_PAGE_TABLE = 6'h01;
   localparam logic [1:0] CLU_T_CTRL_A = 2'h0;
   localparam logic [1:0] CLU_T_CTRL_B = 2'h1;
   localparam logic [1:0] CLU_T_CTRL_C = 2'h2;
   localparam logic [1:0] CLU_T_TRUTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Input source select codes
   localparam logic [3:0] CLU_SRC_MASK = 4'h0;
   localparam logic [3:0] CLU_SRC_FEEDBACK = 4'h1;
   localparam logic [3:0] CLU_SRC_LINK = 4'h2;
   localparam logic [3:0] CLU_SRC_EVENT_A = 4'h3;
   localparam logic [3:0] CLU_SRC_EVENT_B = 4'h4;
   localparam logic [3:0] CLU_SRC_PIN = 4'h5;
   localparam logic [3:0] CLU_SRC_COMPARATOR = 4'h6;
   localparam logic [3:0] CLU_SRC_SERIAL = 4'h8;
   localparam logic [3:0] CLU_SRC_SPI = 4'h9;
   localparam logic [3:0] CLU_SRC_TIMER_A = 4'hA;
   localparam logic [3:0] CLU_SRC_TIMER_B = 4'hC;

   // Output filter select codes
   localparam logic [1:0] CLU_FILT_OFF = 2'h0;
   localparam logic [1:0] CLU_FILT_SYNC = 2'h1;
   localparam logic [1:0] CLU_FILT_FILTER = 2'h2;

   // Sequencer function codes
   localparam logic [3:0] CLU_SEQ_OFF = 4'h0;
   localparam logic [3:0] CLU_SEQ_DFF = 4'h1;
   localparam logic [3:0] CLU_SEQ_JK = 4'h2;
   localparam logic [3:0] CLU_SEQ_DLATCH = 4'h3;
   localparam logic [3:0] CLU_SEQ_RS = 4'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [3:0] CLU_RST_SEL = 4'h0;
   localparam logic [7:0] CLU_RST_TRUTH = 8'h00;
   localparam logic [7:0] CLU_RST_INT_MODE = 8'h00;

   // Control A layout, low bits of the word
   typedef struct packed {
      logic clk_sel;
      logic edge_en;
      logic [1:0] filt;
      logic en;
   } clu_ctrl_a_t;
   localparam clu_ctrl_a_t CLU_RST_CTRL_A = 5'h00;

   // Signal sources feeding the table inputs
   typedef struct packed {
      logic [11:0] table_input_pins;
      logic [3:0] event_input_b;
      logic [3:0] event_input_a;
      logic comparator_output_source;
      logic [2:0] serial_tx;
      logic spi_mosi;
      logic spi_sck;
      logic [2:0] timer_a_outputs;
      logic [2:0] timer_b_outputs;
   } clu_src_t;

endpackage

/* File: core/clu_out_stage.sv */
// Per-table synchronizer, glitch filter and rising-edge detector
`timescale 1ns/1ps
module clu_out_stage
   import clu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic en_i,
   input wire logic tick_i,
   input wire logic [1:0] filt_i,
   input wire logic edge_en_i,
   // Data
   input wire logic d_i,
   output logic q_o
);

   logic s1_reg, s2_reg, s3_reg, held_reg, prev_reg, pulse_reg;
   logic filt_v;

   // Filtered value; off stays purely combinational
   always_comb begin
      filt_v = d_i;
      if (filt_i == CLU_FILT_SYNC) begin
         filt_v = s2_reg;
      end else if (filt_i == CLU_FILT_FILTER) begin
         filt_v = held_reg;
      end
   end

   // Sample chain, cleared the edge after the enable drops
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {s1_reg, s2_reg, s3_reg, held_reg, prev_reg, pulse_reg} <= '0;
      end else if (!en_i) begin
         {s1_reg, s2_reg, s3_reg, held_reg} <= '0;
         {prev_reg, pulse_reg} <= '0;
      end else if (tick_i) begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // Three equal samples before the value may pass
         if (s1_reg == s2_reg && s2_reg == s3_reg) begin
            held_reg <= s3_reg;
         end
         prev_reg <= filt_v;
         pulse_reg <= filt_v & ~prev_reg;
      end
   end

   // Final value, forced low while the table is off
   assign q_o = en_i & (edge_en_i ? pulse_reg : filt_v);

endmodule

/* File: core/clu_sequencer.sv */
// Pair sequencer: gated D flip-flop, JK flip-flop, D latch or RS latch
`timescale 1ns/1ps
module clu_sequencer
   import clu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic clr_i,
   input wire logic tick_i,
   input wire logic [3:0] fn_i,
   // Data: a from the even table, b from the odd table
   input wire logic a_i,
   input wire logic b_i,
   output logic q_o
);

   logic q_reg;

   // Latch modes are sampled like the flops; no true latch in this core
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_reg <= 1'b0;
      end else if (clr_i) begin
         q_reg <= 1'b0;
      end else if (tick_i) begin
         case (fn_i)
            CLU_SEQ_DFF, CLU_SEQ_DLATCH: begin
               if (b_i) begin
                  q_reg <= a_i;
               end
            end
            CLU_SEQ_JK: begin
               unique case ({a_i, b_i})
                  2'b01: q_reg <= 1'b0;
                  2'b10: q_reg <= 1'b1;
                  2'b11: q_reg <= ~q_reg;
                  2'b00: q_reg <= q_reg;
               endcase
            end
            CLU_SEQ_RS: begin
               // Both set and reset high holds the state
               if (a_i && !b_i) begin
                  q_reg <= 1'b1;
               end else if (!a_i && b_i) begin
                  q_reg <= 1'b0;
               end
            end
            default: begin
               q_reg <= 1'b0;
            end
         endcase
      end
   end

   assign q_o = q_reg;

endmodule

/* File: verif/clu_far_end.sv */
// Far side model: pins, events and on-chip peripheral outputs
`timescale 1ns/1ps
module clu_far_end
   import clu_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Requested and driven source levels
   input wire clu_src_t want_i,
   output clu_src_t src_o
);
   // Sources change on the clock; serial and spi act as master
   always_ff @(posedge clk_i) begin
      src_o <= want_i;
   end
endmodule

/* File: verif/clu_top_asserts.sv */
// Port-level assertions of the custom logic unit
`timescale 1ns/1ps
module clu_top_asserts
   import clu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // APB and outputs
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [CLU_TABLES-1:0] table_output_pin_o
);
   logic wr, u_en, en0;
   logic [7:0] tr0, b0;
   assign wr = psel_i && penable_i && pready_o && pwrite_i;
   // Write shadows; protection uses the prior enable
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         u_en <= 1'b0;
         en0 <= 1'b0;
         tr0 <= CLU_RST_TRUTH;
         b0 <= 8'h00;
      end else if (wr) begin
         if (paddr_i == 12'h000) u_en <= pwdata_i[0];
         if (paddr_i == 12'h040) en0 <= pwdata_i[0];
         if (paddr_i == 12'h04C) tr0 <= pwdata_i[7:0];
         if (paddr_i == 12'h044 && !en0) b0 <= pwdata_i[7:0];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_rd(logic [11:0] a);
      psel_i && penable_i && !pwrite_i && paddr_i == a;
   endsequence
   property p_ready;
      psel_i && penable_i |-> pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_bad;
      psel_i && penable_i && (paddr_i[1:0] != 2'b00 || paddr_i == 12'h018) |-> pslverr_o;
   endproperty
   a_bad: assert property (p_bad) else $error("no slave error");
   property p_bad_rd;
      s_rd(12'h018) |-> prdata_o == 32'h0000_0000;
   endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
   property p_unit_off;
      !u_en [*3] |-> table_output_pin_o == 4'h0;
   endproperty
   a_unit_off: assert property (p_unit_off) else $error("output with unit off");
   property p_t0_off;
      !en0 [*3] |-> !table_output_pin_o[0];
   endproperty
   a_t0_off: assert property (p_t0_off) else $error("output with table off");
   property p_truth;
      s_rd(12'h04C) |-> prdata_o[7:0] == tr0;
   endproperty
   a_truth: assert property (p_truth) else $error("truth readback");
   property p_prot;
      s_rd(12'h044) |-> prdata_o[7:0] == b0;
   endproperty
   a_prot: assert property (p_prot) else $error("protected select changed");
   property p_status;
      s_rd(12'h014) ##0 $stable(table_output_pin_o) |-> prdata_o[3:0] == table_output_pin_o;
   endproperty
   a_status: assert property (p_status) else $error("status differs from pins");
endmodule
bind clu_top clu_top_asserts u_asserts (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .table_output_pin_o(table_output_pin_o));

/* File: verif/clu_top_bench.sv */
// Self-checking bench of the custom logic unit
`timescale 1ns/1ps
module clu_top_bench
   import clu_pkg::*;
;
   logic clk_i;
   logic nrst_i;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pin;
   clu_src_t want, src;
   int mismatches, compares;
   clu_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .src_i(src), .table_output_pin_o(pin),
      .irq_o(irq));
   clu_far_end far (.clk_i(clk_i), .want_i(want), .src_o(src));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One transfer, then an idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 50) mismatches++;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   function automatic logic [11:0] ta(input int n, input int w);
      return 12'(12'h040 + n * 16 + w * 4);
   endfunction
   // Disable, set fields, then enable
   task automatic cfg(input int n, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] c, input logic [31:0] t);
      wr(ta(n, 0), 32'h0000_0000);
      wr(ta(n, 1), b);
      wr(ta(n, 2), c);
      wr(ta(n, 3), t);
      wr(ta(n, 0), a);
   endtask
   // Source of code c for table 1 input 0; else all high
   function automatic clu_src_t one(input logic [3:0] c);
      clu_src_t s;
      s = '0;
      case (c)
         4'h3: s.event_input_a[1] = 1'b1;
         4'h4: s.event_input_b[1] = 1'b1;
         4'h5: s.table_input_pins[3] = 1'b1;
         4'h6: s.comparator_output_source = 1'b1;
         4'h8: s.serial_tx[0] = 1'b1;
         4'h9: s.spi_mosi = 1'b1;
         4'hA: s.timer_a_outputs[0] = 1'b1;
         4'hC: s.timer_b_outputs[0] = 1'b1;
         default: s = '1;
      endcase
      return s;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task automatic t_codes();
      logic e;
      for (int c = 0; c < 16; c++) begin
         e = c inside {3, 4, 5, 6, 8, 9, 10, 12};
         want <= '0;
         cfg(1, 32'h0000_0001, 32'(c), 32'h0000_0000, 32'h0000_0002);
         cyc(4);
         chk(32'(pin[1]), 32'h0000_0000);
         want <= one(4'(c));
         cyc(4);
         chk(32'(pin[1]), 32'(e));
      end
   endtask
   task automatic t_truth();
      logic [7:0] t;
      t = 8'hB4;
      cfg(0, 32'h0000_0001, 32'h0000_0088, 32'h0000_0008, 32'(t));
      for (int i = 0; i < 8; i++) begin
         want.serial_tx <= 3'(i);
         cyc(3);
         chk(32'(pin[0]), 32'(t[i]));
      end
      rd(ta(0, 3));
      chk(q, 32'(t));
   endtask
   // Odd table guarded by the even enable
   task automatic t_prot();
      wr(ta(0, 1), 32'h0000_0055);
      wr(ta(1, 1), 32'h0000_0033);
      wr(12'h004, 32'h0000_0004);
      rd(ta(0, 1));
      chk(q, 32'h0000_0088);
      rd(ta(1, 1));
      chk(q, 32'h0000_000F);
      rd(12'h004);
      chk(q, 32'h0000_0000);
      wr(ta(0, 0), 32'h0000_0002);
      rd(ta(0, 0));
      chk(q, 32'h0000_0000);
      wr(ta(0, 0), 32'h0000_0003);
      rd(ta(0, 0));
      chk(q, 32'h0000_0003);
      rd(12'h018);
   endtask
   // Cycles counted on falling edges, after flops settle
   task automatic lag(input logic [31:0] a, output int n);
      cfg(0, a, 32'h0000_0008, 32'h0000_0000, 32'h0000_0002);
      want <= '0;
      cyc(8);
      want.serial_tx[0] <= 1'b1;
      n = 0;
      while (pin[0] !== 1'b1 && n < 30) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
   endtask
   task automatic t_lag();
      int n0, n;
      lag(32'h0000_0001, n0);
      lag(32'h0000_0003, n);
      chk(32'(n), 32'(n0 + 2));
      lag(32'h0000_0005, n);
      chk(32'(n), 32'(n0 + 4));
      lag(32'h0000_000D, n);
      chk(32'(n), 32'(n0 + 5));
      @(negedge clk_i);
      chk(32'(pin[0]), 32'h0000_0000);
      @(posedge clk_i);
   endtask
   task automatic highs(input int k, output int h);
      h = 0;
      repeat (k) begin
         @(negedge clk_i);
         if (pin[0] !== 1'b0) h++;
      end
      @(posedge clk_i);
   endtask
   // Spike must not pass; a primed filter must not survive a disable
   task automatic t_glitch();
      int h;
      cfg(0, 32'h0000_0005, 32'h0000_0008, 32'h0000_0000, 32'h0000_0002);
      want <= '0;
      cyc(8);
      want.serial_tx[0] <= 1'b1;
      cyc(1);
      want.serial_tx[0] <= 1'b0;
      highs(12, h);
      chk(32'(h), 32'h0000_0000);
      want.serial_tx[0] <= 1'b1;
      cyc(10);
      wr(ta(0, 0), 32'h0000_0004);
      want.serial_tx[0] <= 1'b0;
      cyc(2);
      wr(ta(0, 0), 32'h0000_000D);
      highs(8, h);
      chk(32'(h), 32'h0000_0000);
   endtask
   // Table 3 takes table 0's direct result, not its edge pulse
   task automatic t_link();
      cfg(3, 32'h0000_0001, 32'h0000_0002, 32'h0000_0000, 32'h0000_0002);
      wr(ta(0, 3), 32'h0000_00FF);
      cyc(10);
      chk(32'(pin[3]), 32'h0000_0001);
      rd(12'h014);
      wr(ta(0, 3), 32'h0000_0000);
      cyc(10);
      chk(32'(pin[3]), 32'h0000_0000);
      wr(ta(0, 3), 32'h0000_00FF);
      cyc(10);
      wr(12'h000, 32'h0000_0000);
      cyc(3);
      chk(32'(pin), 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Watchdog, far beyond the run's length
   initial begin
      repeat (8000) @(posedge clk_i);
      mismatches++;
      print_verdict();
   end
   initial begin
      nrst_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      want = '0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      wr(12'h000, 32'h0000_0001);
      t_codes();
      t_truth();
      t_prot();
      t_lag();
      t_glitch();
      t_link();
      print_verdict();
   end
endmodule
